// [logic/ffr_defines.svh]
// Constants for the fault event flag register block.
`ifndef FFR_DEFINES_SVH
`define FFR_DEFINES_SVH
`define FFR_ADDR_W 8
`define FFR_DATA_W 8
`define FFR_FLAG_ADDR 8'h04
`define FFR_CTRL1_ADDR 8'h01
`define FFR_FLAG_RESET 8'h02
`define FFR_SWRST_BIT 7
`define FFR_NUM_EVENTS 6
`define FFR_BIT_RETRY 5
`define FFR_BIT_CURRENT_LIMIT_EVENT_FLAG 4
`define FFR_BIT_THERMAL_WARNING_FLAG 3
`define FFR_BIT_THERMAL_SHUTDOWN_FLAG 2
`define FFR_BIT_UV 1
`define FFR_BIT_OV 0
`define FFR_RSVD_MSB 7
`define FFR_RSVD_LSB 6
`define FFR_UNMAPPED_DATA 8'h00
`endif

// [logic/ffr_pkg.sv]
// Types shared by the fault event flag register block.
`include "ffr_defines.svh"
package ffr_pkg;
  typedef struct packed {
    logic retryEvent;
    logic currentLimitEvent;
    logic thermalWarningEvent;
    logic thermalShutdownEvent;
    logic outputUndervoltageEvent;
    logic outputOvervoltageEvent;
  } ffr_events_t;
  typedef struct packed {
    logic rdStb;
    logic wrStb;
    logic [`FFR_ADDR_W-1:0] addr;
    logic [`FFR_DATA_W-1:0] wdata;
  } ffr_req_t;
  typedef enum logic [1:0] {
    FFR_IDLE = 2'h1,
    FFR_CLEAR = 2'h2
  } ffr_state_t;
endpackage

// [logic/ffr_flag_cell.sv]
// One sticky event flag with set-over-clear priority.
`timescale 1ns/100ps
`default_nettype none
module ffr_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic softReset,
  input wire logic eventIn,
  input wire logic clearReq,
  output logic flag_q
);
  logic flag_d;
  // A new event beats a clear arriving in the same cycle.
  assign flag_d = softReset ? RESET_VAL : (eventIn | (flag_q & ~clearReq));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q <= RESET_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule
`default_nettype wire

// [logic/fault_event_flag_register.sv]
// Sticky fault and event flag register reached through the control interface.
`timescale 1ns/100ps
`default_nettype none
`include "ffr_defines.svh"
module fault_event_flag_register
  import ffr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ffr_req_t req,
  input wire ffr_events_t events,
  output logic [`FFR_DATA_W-1:0] rdata_q,
  output logic rvalid_q
);
  localparam logic [`FFR_DATA_W-1:0] RESET_VALUE = `FFR_FLAG_RESET;

  function automatic logic addrHit(input logic [`FFR_ADDR_W-1:0] a,
                                   input logic [`FFR_ADDR_W-1:0] target);
    addrHit = (a == target);
  endfunction

  ffr_state_t state_q;
  ffr_state_t state_d;
  logic [`FFR_NUM_EVENTS-1:0] flags;
  logic [`FFR_NUM_EVENTS-1:0] eventVec;
  logic flagRead;
  logic ctrlWrite;
  logic softReset;
  logic clearReq;
  logic [`FFR_DATA_W-1:0] flagWord;
  logic [`FFR_DATA_W-1:0] readMux;
  logic [`FFR_NUM_EVENTS-1:0] readEvents_d;
  logic [`FFR_NUM_EVENTS-1:0] readEvents_q;
  logic [`FFR_NUM_EVENTS-1:0] clearMask;
  logic [`FFR_NUM_EVENTS-1:0] keepMask;

  assign eventVec = events;
  // Register reads are decoded here; other addresses belong to sibling blocks.
  assign flagRead = req.rdStb & addrHit(req.addr, `FFR_FLAG_ADDR);
  assign ctrlWrite = req.wrStb & addrHit(req.addr, `FFR_CTRL1_ADDR);
  assign softReset = ctrlWrite & req.wdata[`FFR_SWRST_BIT];
  // The clear lands one cycle after the read snapshot, so nothing is lost.
  assign clearReq = (state_q == FFR_CLEAR);
  // Events seen during the read cycle missed the snapshot, so the clear spares them.
  assign readEvents_d = flagRead ? eventVec : '0;
  assign clearMask = {`FFR_NUM_EVENTS{clearReq}} & ~readEvents_q;
  assign keepMask = flags & ~clearMask;
  // Reserved bits are forced to zero.
  assign flagWord = {2'h0, flags};

  always_comb begin
    if (flagRead) begin
      readMux = flagWord;
    end else if (req.rdStb & addrHit(req.addr, `FFR_CTRL1_ADDR)) begin
      readMux = `FFR_UNMAPPED_DATA;
    end else begin
      readMux = `FFR_UNMAPPED_DATA;
    end
  end

  always_comb begin
    case (state_q)
      FFR_IDLE: begin
        state_d = flagRead ? FFR_CLEAR : FFR_IDLE;
      end
      FFR_CLEAR: begin
        state_d = flagRead ? FFR_CLEAR : FFR_IDLE;
      end
      default: begin
        state_d = FFR_IDLE;
      end
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < `FFR_NUM_EVENTS; gi++) begin : g_flag
      // One cell per flag bit; bit 1 resets high.
      ffr_flag_cell #(
        .RESET_VAL(RESET_VALUE[gi])
      ) u_cell (
        .clk(clk),
        .rst(rst),
        .softReset(softReset),
        .eventIn(eventVec[gi]),
        .clearReq(clearMask[gi] & ~softReset),
        .flag_q(flags[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= FFR_IDLE;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      readEvents_q <= '0;
    end else begin
      state_q <= softReset ? FFR_IDLE : state_d;
      rdata_q <= readMux;
      rvalid_q <= req.rdStb;
      readEvents_q <= readEvents_d;
    end
  end

  property p_reset_value;
    @(posedge clk) disable iff (rst)
      softReset |=> (flags == RESET_VALUE[`FFR_NUM_EVENTS-1:0]);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("Soft reset missed.");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
      rvalid_q |-> (rdata_q[`FFR_RSVD_MSB:`FFR_RSVD_LSB] == 2'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits set.");

  property p_read_data;
    @(posedge clk) disable iff (rst)
      flagRead |=> (rdata_q == {2'h0, $past(flags)}) && rvalid_q;
  endproperty
  a_read_data: assert property (p_read_data) else $error("Read data wrong.");

  property p_retry_set;
    @(posedge clk) disable iff (rst)
      (events.retryEvent && !softReset) |=> flags[`FFR_BIT_RETRY];
  endproperty
  a_retry_set: assert property (p_retry_set) else $error("Retry flag not set.");

  property p_current_limit_event_flag_set;
    @(posedge clk) disable iff (rst)
      (events.currentLimitEvent && !softReset) |=> flags[`FFR_BIT_CURRENT_LIMIT_EVENT_FLAG];
  endproperty
  a_current_limit_event_flag_set: assert property (p_current_limit_event_flag_set) else $error("Limit flag not set.");

  property p_thermal_warning_flag_hold;
    @(posedge clk) disable iff (rst)
      (flags[`FFR_BIT_THERMAL_WARNING_FLAG] && !clearMask[`FFR_BIT_THERMAL_WARNING_FLAG] && !softReset) |=>
        flags[`FFR_BIT_THERMAL_WARNING_FLAG];
  endproperty
  a_thermal_warning_flag_hold: assert property (p_thermal_warning_flag_hold) else $error("Warning flag lost.");

  property p_thermal_shutdown_flag_set;
    @(posedge clk) disable iff (rst)
      (events.thermalShutdownEvent && !softReset) |=> flags[`FFR_BIT_THERMAL_SHUTDOWN_FLAG];
  endproperty
  a_thermal_shutdown_flag_set: assert property (p_thermal_shutdown_flag_set) else $error("Shutdown flag not set.");

  property p_uv_set;
    @(posedge clk) disable iff (rst)
      (events.outputUndervoltageEvent && !softReset) |=> flags[`FFR_BIT_UV];
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("Undervoltage flag not set.");

  property p_ov_set;
    @(posedge clk) disable iff (rst)
      (events.outputOvervoltageEvent && !softReset) |=> flags[`FFR_BIT_OV];
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("Overvoltage flag not set.");

  property p_clear_after_read;
    @(posedge clk) disable iff (rst)
      (flagRead && !softReset && eventVec == '0) ##1 (!softReset && eventVec == '0) |=>
        (flags == '0);
  endproperty
  a_clear_after_read: assert property (p_clear_after_read) else $error("Flags not cleared.");

  property p_rvalid_follows;
    @(posedge clk) disable iff (rst)
      req.rdStb |=> rvalid_q;
  endproperty
  a_rvalid_follows: assert property (p_rvalid_follows) else $error("Read answer missing.");

  property p_rvalid_idle;
    @(posedge clk) disable iff (rst)
      !req.rdStb |=> !rvalid_q;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("Stray read answer.");

  property p_unmapped_zero;
    @(posedge clk) disable iff (rst)
      !flagRead |=> (rdata_q == `FFR_UNMAPPED_DATA);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("Other read not zero.");

  // A flag raised during the read cycle was not reported, so it must outlive the clear.
  property p_read_event_kept;
    @(posedge clk) disable iff (rst)
      (flagRead && !softReset) ##1 !softReset |=>
        ((flags & $past(eventVec, 2)) == $past(eventVec, 2));
  endproperty
  a_read_event_kept: assert property (p_read_event_kept) else $error("Read event lost.");

  property p_flag_keep;
    @(posedge clk) disable iff (rst)
      !softReset |=> ((flags & $past(keepMask)) == $past(keepMask));
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("Flag dropped early.");

  property p_clear_done;
    @(posedge clk) disable iff (rst)
      (clearReq && !softReset) |=> ((flags & $past(clearMask) & ~$past(eventVec)) == '0);
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("Reported flag kept.");

  property p_no_spurious_set;
    @(posedge clk) disable iff (rst)
      !softReset |=> ((flags & ~$past(flags) & ~$past(eventVec)) == '0);
  endproperty
  a_no_spurious_set: assert property (p_no_spurious_set) else $error("Flag set without event.");

  property p_clear_follows;
    @(posedge clk) disable iff (rst)
      flagRead |=> clearReq;
  endproperty
  a_clear_follows: assert property (p_clear_follows) else $error("Clear missing after read.");

  property p_no_stray_clear;
    @(posedge clk) disable iff (rst)
      !flagRead |=> !clearReq;
  endproperty
  a_no_stray_clear: assert property (p_no_stray_clear) else $error("Clear without read.");

  c_read: cover property (@(posedge clk) disable iff (rst) flagRead ##1 clearReq);
  c_event_on_clear: cover property (@(posedge clk) disable iff (rst) clearReq && eventVec != '0);
  c_soft_reset: cover property (@(posedge clk) disable iff (rst) softReset);
  c_read_event: cover property (@(posedge clk) disable iff (rst) flagRead && eventVec != '0);
  c_unmapped_read: cover property (@(posedge clk) disable iff (rst) req.rdStb && !flagRead);
endmodule
`default_nettype wire

// [verif/ffr_host_model.sv]
// Host controller model issuing single-byte register accesses.
`timescale 1ns/100ps
`default_nettype none
`include "ffr_defines.svh"
module ffr_host_model
  import ffr_pkg::*;
(
  input wire logic clk,
  output var ffr_req_t req,
  input wire logic [`FFR_DATA_W-1:0] rdata_q,
  input wire logic rvalid_q
);
  initial req = '{1'b0, 1'b0, 8'hFF, 8'hFF};
  // Idle address and data show the inverse of the last value so stale lines never match.
  // Reserved bits are returned untouched so the bench can judge them.
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
    @(posedge clk);
    req <= '{~wr, wr, a, d};
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~a, ~d};
    #1;
    q = rdata_q;
    v = rvalid_q;
  endtask
endmodule
`default_nettype wire

// [verif/fault_event_flag_register_tb_top.sv]
// Self-checking bench for the fault event flag register.
`timescale 1ns/100ps
`default_nettype none
`include "ffr_defines.svh"
module fault_event_flag_register_tb_top;
  import ffr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ffr_req_t req;
  ffr_events_t events = '0;
  logic [7:0] rdataQ;
  logic rvalidQ;
  int miscompares = 0;
  int n_tests = 0;
  fault_event_flag_register i_dut (.clk(clk), .rst(rst), .req(req), .events(events),
    .rdata_q(rdataQ), .rvalid_q(rvalidQ));
  ffr_host_model i_host (.clk(clk), .req(req), .rdata_q(rdataQ), .rvalid_q(rvalidQ));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic v;
    i_host.access(1'b0, a, 8'h00, q, v);
    n_tests++;
    if (q !== exp || v !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t addr %h got %h valid %b exp %h", $time, a, q, v, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic v;
    i_host.access(1'b1, a, d, q, v);
  endtask
  task automatic pulse(input ffr_events_t e);
    @(posedge clk);
    events <= e;
    @(posedge clk);
    events <= '0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`FFR_FLAG_ADDR, `FFR_FLAG_RESET);
    rd(`FFR_FLAG_ADDR, 8'h00);
    $display("test reset done");
    for (int i = 0; i < `FFR_NUM_EVENTS; i++) begin
      pulse(ffr_events_t'(6'h01 << i));
      rd(8'h05, 8'h00);
      rd(`FFR_FLAG_ADDR, 8'h01 << i);
      rd(`FFR_FLAG_ADDR, 8'h00);
    end
    $display("test single events done");
    @(posedge clk);
    events <= 6'h3F;
    rd(`FFR_FLAG_ADDR, 8'h3F);
    @(posedge clk);
    events <= '0;
    rd(`FFR_FLAG_ADDR, 8'h3F);
    rd(`FFR_FLAG_ADDR, 8'h00);
    $display("test event during read done");
    pulse(ffr_events_t'(6'h01));
    // Shutdown arrives in the read cycle and warning in the clear cycle; both must survive.
    fork
      rd(`FFR_FLAG_ADDR, 8'h01);
      begin
        @(posedge clk);
        events <= ffr_events_t'(6'h04);
        @(posedge clk);
        events <= ffr_events_t'(6'h08);
        @(posedge clk);
        events <= '0;
      end
    join
    rd(`FFR_FLAG_ADDR, 8'h0C);
    rd(`FFR_FLAG_ADDR, 8'h00);
    $display("test event in read and clear cycles done");
    pulse(ffr_events_t'(6'h21));
    wr(`FFR_CTRL1_ADDR, 8'h7F);
    rd(`FFR_FLAG_ADDR, 8'h21);
    pulse(ffr_events_t'(6'h21));
    wr(`FFR_CTRL1_ADDR, 8'h80);
    rd(`FFR_FLAG_ADDR, `FFR_FLAG_RESET);
    rd(`FFR_CTRL1_ADDR, 8'h00);
    pulse(ffr_events_t'(6'h08));
    wr(`FFR_FLAG_ADDR, 8'hFF);
    rd(`FFR_FLAG_ADDR, 8'h08);
    $display("test soft reset done");
    pulse(ffr_events_t'(6'h10));
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(`FFR_FLAG_ADDR, `FFR_FLAG_RESET);
    $display("test mid-run reset done");
    final_report();
  end
  // The tests take well under a thousand cycles, so this span only trips on a hang.
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
